// *** logic/vpsc_pkg.sv ***
// Package for the emulated PHY special control/status register.
// Assumes a single system clock domain; imported by the design only, not by the bench.
package vpsc_pkg;
  // Register placement in the system register space
  localparam logic [11:0] VPSC_REG_OFFSET   = 12'h1DC;
  localparam logic [4:0]  VPSC_REG_INDEX    = 5'h1F;
  // Field positions
  localparam int          VPSC_LOOPBACK_BIT = 14;
  localparam int          VPSC_COLTEST_BIT  = 7;
  localparam int          VPSC_DUPLEX_BIT   = 4;
  localparam int          VPSC_SPEED_HI     = 3;
  localparam int          VPSC_SPEED_LO     = 2;
  localparam int          VPSC_HBDIS_BIT    = 0;
  // Reset values
  localparam logic        VPSC_LOOPBACK_RST = 1'h0;
  localparam logic        VPSC_COLTEST_RST  = 1'h0;
  // Speed codes of bits 3:2
  localparam logic [1:0]  VPSC_SPEED_10     = 2'h1;
  localparam logic [1:0]  VPSC_SPEED_100    = 2'h2;
endpackage : vpsc_pkg

// *** logic/vpsc_special_ctrl.sv ***
// Emulated PHY special control/status register and its datapath effects.
// Assumes system-clock access ports, a same-clock emulated PHY core, and
// strap input arriving from a pin.
// Address decode of the register offset sits outside; reg_wr and reg_rd
// arrive already qualified. Reserved bits are never stored at all.
// The strap is judged only once its synchroniser has filled, so bit 0 of a write
// in the first few clocks after reset is overridden by the strap load.
//
// Operation
// [RULE1] Loopback bit returns host transmissions into engine
// [RULE2] Collision test asserts collision during engine transmit
// [RULE3] Bits 4:2 report duplex and speed
// [RULE4] Bit 0 one disables heartbeat test
// [RULE5] 32-bit word, 16-bit view over management
// [RULE6] Autoneg enabled: indication from negotiation result
// [RULE7] Autoneg off: indication from basic control bits
// [RULE8] Emulated PHY reset clears resettable bits
// [RULE9] Heartbeat disable resets from strap level
// [RULE10] Reserved bits read zero; no reserved code
`timescale 1ns/100ps
`default_nettype none
module vpsc_special_ctrl
  import vpsc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  // System register access, one aligned word
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  // Management (serial) access, 16-bit view
  input  wire logic        mgmt_wr,
  input  wire logic [15:0] mgmt_wdata,
  output logic      [15:0] mgmt_rdata,
  // Emulated PHY context
  input  wire logic        emulated_autoneg_enable,
  input  wire logic        emulated_speed_select_low,
  input  wire logic        emulated_duplex_mode,
  input  wire logic        autoneg_full_duplex,
  input  wire logic        autoneg_speed_100,
  input  wire logic        emulated_phy_reset_bit,
  input  wire logic        emulated_phy_reset_req,
  input  wire logic        heartbeat_disable_strap,
  // Host port datapath
  input  wire logic        host_tx_valid,
  input  wire logic [7:0]  host_tx_data,
  input  wire logic        engine_tx_active,
  output logic             host_side_tx_valid,
  output logic      [7:0]  host_side_tx_data,
  output logic             engine_rx_valid,
  output logic      [7:0]  engine_rx_data,
  output logic             host_collision,
  output logic             heartbeat_test_disable
);
  // Control bits held by the register
  logic        loopback_en;
  logic        collision_test_en;
  logic        hb_disable;
  // Strap synchroniser, its fill marker and the one-shot load flag
  logic [2:0]  strap_sync;
  logic [2:0]  strap_fill;
  logic        strap_settled;
  logic        strap_loaded;
  // Speed/duplex indication and the assembled read image
  logic        speed_100;
  logic        full_duplex;
  logic [15:0] reg_view;
  // Write path shared by both access ports
  logic        any_wr;
  logic [15:0] wdata;
  logic        wr_loopback;
  logic        wr_coltest;
  logic        wr_hbdis;
  logic        phy_soft_reset;

  // Either access port may write; management wins if both coincide
  // Only the low half of a system word ever reaches the register
  assign any_wr = mgmt_wr | reg_wr;
  assign wdata  = mgmt_wr ? mgmt_wdata : reg_wdata[15:0];
  assign phy_soft_reset = emulated_phy_reset_req & emulated_phy_reset_bit; // RULE8

  // Writable fields picked out once; the reserved bits fall away here
  assign wr_loopback = wdata[VPSC_LOOPBACK_BIT]; // RULE10
  assign wr_coltest  = wdata[VPSC_COLTEST_BIT];
  assign wr_hbdis    = wdata[VPSC_HBDIS_BIT];

  // Strap passes three flops; load once second and third agree
  // The pin is asynchronous, so the first stage may go metastable
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      strap_sync <= 3'h0;
    else
      strap_sync <= {strap_sync[1:0], heartbeat_disable_strap};
  end

  // Fill marker: a one walks in behind reset, so the cleared
  // synchroniser stages are never mistaken for the strap level
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      strap_fill <= 3'h0;
    else
      strap_fill <= {strap_fill[1:0], 1'h1};
  end

  // Strap level counts once filled and the last two stages agree
  assign strap_settled = strap_fill[2] && (strap_sync[2] == strap_sync[1]); // RULE9

  // Loopback control
  // Soft reset outranks a write landing in the same cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      loopback_en <= VPSC_LOOPBACK_RST;
    else if (phy_soft_reset)
      loopback_en <= VPSC_LOOPBACK_RST; // RULE8
    else if (any_wr)
      loopback_en <= wr_loopback; // RULE1
  end

  // Collision test control
  // Intended for use with loopback on; nothing here enforces that
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      collision_test_en <= VPSC_COLTEST_RST;
    else if (phy_soft_reset)
      collision_test_en <= VPSC_COLTEST_RST; // RULE8
    else if (any_wr)
      collision_test_en <= wr_coltest; // RULE2
  end

  // Heartbeat disable; strap level captured after reset release, not at it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hb_disable   <= 1'h0;
      strap_loaded <= 1'h0;
    end
    else if (!strap_loaded && strap_settled)
    begin
      hb_disable   <= strap_sync[2]; // RULE9
      strap_loaded <= 1'h1;
    end
    else if (phy_soft_reset)
      hb_disable <= strap_sync[2]; // RULE9
    else if (any_wr)
      hb_disable <= wr_hbdis; // RULE4
  end

  // Speed/duplex source select; two valid codes only, never reserved
  // A mux, not a stored copy, so the field follows its source with no lag
  assign speed_100   = emulated_autoneg_enable ? autoneg_speed_100 : emulated_speed_select_low; // RULE6 RULE7
  assign full_duplex = emulated_autoneg_enable ? autoneg_full_duplex : emulated_duplex_mode; // RULE6 RULE7

  // Read view: reserved bits tied to zero
  // One image built from the live bits serves both access paths
  always_comb
  begin
    reg_view = 16'h0000; // RULE10
    reg_view[VPSC_LOOPBACK_BIT] = loopback_en;
    reg_view[VPSC_COLTEST_BIT]  = collision_test_en;
    reg_view[VPSC_DUPLEX_BIT]   = full_duplex; // RULE3
    reg_view[VPSC_SPEED_HI:VPSC_SPEED_LO] = speed_100 ? VPSC_SPEED_100 : VPSC_SPEED_10; // RULE3 RULE10
    reg_view[VPSC_HBDIS_BIT]    = hb_disable;
  end

  // Management view refreshes every cycle, one clock behind the state
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      mgmt_rdata <= 16'h0000;
    else
      mgmt_rdata <= reg_view; // RULE5
  end

  // Word read captured only on request and held until the next one;
  // upper half pads the word with zeros
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 32'h00000000;
    else if (reg_rd)
      reg_rdata <= {16'h0000, reg_view}; // RULE5
  end

  // Host side: frames pass only while loopback is off; data parked at
  // zero otherwise so no stale byte leaks toward the host
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      host_side_tx_valid <= 1'h0;
      host_side_tx_data  <= 8'h00;
    end
    else
    begin
      host_side_tx_valid <= host_tx_valid & ~loopback_en; // RULE1
      host_side_tx_data  <= loopback_en ? 8'h00 : host_tx_data; // RULE1
    end
  end

  // Engine side: far loopback returns host frames into the switch engine
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      engine_rx_valid <= 1'h0;
      engine_rx_data  <= 8'h00;
    end
    else
    begin
      engine_rx_valid <= host_tx_valid & loopback_en; // RULE1
      engine_rx_data  <= loopback_en ? host_tx_data : 8'h00; // RULE1
    end
  end

  // Collision follows engine transmit combinationally, no added latency
  assign host_collision         = collision_test_en & engine_tx_active; // RULE2

  // Heartbeat test control goes straight out of the register bit
  assign heartbeat_test_disable = hb_disable; // RULE4
endmodule : vpsc_special_ctrl
`default_nettype wire

// *** bench/vpsc_host_mac.sv ***
// Host MAC model feeding transmit bytes into the host port path.
// Assumes the bench gates it with en; it drives on the falling edge.
`timescale 1ns/100ps
`default_nettype none
module vpsc_host_mac (
  input  wire logic       clk,
  input  wire logic       en,
  output logic            tx_valid,
  output logic      [7:0] tx_data
);
  initial {tx_valid, tx_data} = 9'h0;
  // Random bursts; idle data toggles so a stale byte never looks valid
  always @(negedge clk)
  begin
    tx_valid <= en && $urandom_range(1) != 0;
    tx_data  <= en ? 8'($urandom) : ~tx_data;
  end
endmodule : vpsc_host_mac
`default_nettype wire

// *** bench/vpsc_monitor.sv ***
// Checker on the special control/status register ports.
// Assumes one system clock and an asynchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module vpsc_monitor (
  input wire logic        clk, rst, mgmt_wr, host_tx_valid, host_side_tx_valid, engine_rx_valid, host_collision,
  input wire logic        engine_tx_active, heartbeat_test_disable, emulated_phy_reset_bit, emulated_phy_reset_req,
  input wire logic        emulated_autoneg_enable, emulated_speed_select_low, emulated_duplex_mode,
  input wire logic        autoneg_full_duplex, autoneg_speed_100,
  input wire logic [7:0]  host_tx_data, engine_rx_data,
  input wire logic [15:0] mgmt_wdata, mgmt_rdata,
  input wire logic [31:0] reg_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Expected code; never a reserved one whatever the source
  logic [2:0] view;
  assign view = emulated_autoneg_enable ? {autoneg_full_duplex, autoneg_speed_100 ? 2'h2 : 2'h1}
                                        : {emulated_duplex_mode, emulated_speed_select_low ? 2'h2 : 2'h1};
  sequence s_steady;
    (!$past(rst) && $stable({view, emulated_autoneg_enable})) [*2];
  endsequence
  sequence s_write;
    mgmt_wr && !emulated_phy_reset_req && !$past(rst, 4);
  endsequence
  property p_resv; (mgmt_rdata & 16'hBF62) == 16'h0 && reg_rdata[31:16] == 16'h0; endproperty
  a_resv: assert property (p_resv) else $error("reserved bits not zero");
  property p_view; s_steady |-> mgmt_rdata[4:2] == view; endproperty
  a_view: assert property (p_view) else $error("speed duplex code wrong");
  property p_col; (host_collision |-> engine_tx_active) and
    (engine_tx_active |=> mgmt_rdata[7] == $past(host_collision)); endproperty
  a_col: assert property (p_col) else $error("collision without engine transmit");
  property p_route; host_tx_valid |=> host_side_tx_valid != engine_rx_valid && engine_rx_valid == mgmt_rdata[14];
  endproperty
  a_route: assert property (p_route) else $error("byte not routed to one side");
  property p_data; engine_rx_valid |-> engine_rx_data == $past(host_tx_data); endproperty
  a_data: assert property (p_data) else $error("looped byte corrupted");
  property p_hb; s_write |=> heartbeat_test_disable == $past(mgmt_wdata[0]); endproperty
  a_hb: assert property (p_hb) else $error("heartbeat disable not written");
  property p_lb; s_write |=> ##1 mgmt_rdata[14] == $past(mgmt_wdata[14], 2); endproperty
  a_lb: assert property (p_lb) else $error("loopback bit not written");
  property p_soft; emulated_phy_reset_bit && emulated_phy_reset_req |=> !host_collision ##1 mgmt_rdata[14] == 1'h0;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset left bits set");
endmodule : vpsc_monitor
bind vpsc_special_ctrl vpsc_monitor i_vpsc_monitor (.clk, .rst, .mgmt_wr, .host_tx_valid, .host_side_tx_valid,
  .engine_rx_valid, .host_collision, .engine_tx_active, .heartbeat_test_disable, .emulated_phy_reset_bit,
  .emulated_phy_reset_req, .emulated_autoneg_enable, .emulated_speed_select_low, .emulated_duplex_mode,
  .autoneg_full_duplex, .autoneg_speed_100, .host_tx_data, .engine_rx_data, .mgmt_wdata, .mgmt_rdata, .reg_rdata);
`default_nettype wire

// *** bench/tb_virtual_phy_special_ctrl_status.sv ***
// Self-checking bench for the special control/status register.
// Assumes the host MAC model and the bound checker beside the design.
`timescale 1ns/100ps
`default_nettype none
module tb_virtual_phy_special_ctrl_status;
  logic clk = 0, rst = 1, rw = 0, rr = 0, mw = 0, an = 0, ssl = 0, dup = 0, afd = 0, a100 = 0, prb = 0, prq = 0;
  logic strap = 1, en = 0, eta = 0, lb = 0, ct = 0, hb = 1, v, htv, hsv, erv, col, hbd;
  logic [31:0] wd = 0, rd, d;
  logic [15:0] mrd;
  logic [7:0]  htd, hsd, erd, b;
  int          error_cnt = 0, comparisons = 0;
  always #20 clk = ~clk;
  vpsc_host_mac i_vpsc_host_mac (.clk, .en, .tx_valid(htv), .tx_data(htd));
  vpsc_special_ctrl i_vpsc_special_ctrl (.clk, .rst, .reg_wr(rw), .reg_rd(rr), .reg_wdata(wd), .reg_rdata(rd),
    .mgmt_wr(mw), .mgmt_wdata(wd[15:0]), .mgmt_rdata(mrd), .emulated_autoneg_enable(an),
    .emulated_speed_select_low(ssl), .emulated_duplex_mode(dup), .autoneg_full_duplex(afd), .autoneg_speed_100(a100),
    .emulated_phy_reset_bit(prb), .emulated_phy_reset_req(prq), .heartbeat_disable_strap(strap),
    .host_tx_valid(htv), .host_tx_data(htd), .engine_tx_active(eta), .host_side_tx_valid(hsv),
    .host_side_tx_data(hsd), .engine_rx_valid(erv), .engine_rx_data(erd), .host_collision(col),
    .heartbeat_test_disable(hbd));
  // Expected word from the bench's own copy of the control bits
  function automatic logic [31:0] exp_reg();
    return {17'h0, lb, 6'h0, ct, 2'h0, an ? afd : dup, (an ? a100 : ssl) ? 2'h2 : 2'h1, 1'h0, hb};
  endfunction : exp_reg
  task automatic chk(logic [31:0] g, logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Writes and reads are pulses of one cycle, launched off the falling edge
  task automatic wr(logic m, logic [31:0] x);
    {wd, rw, mw} = {x, !m, m};
    @(negedge clk) {rw, mw} = 2'h0;
  endtask : wr
  task automatic rdchk();
    rr = 1;
    @(negedge clk) rr = 0;
    chk(rd, exp_reg());
    chk(32'(mrd), exp_reg() & 32'h0000FFFF);
  endtask : rdchk
  task automatic end_sim();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim
  initial
  begin
    void'($urandom(32'h817d));
    repeat (5) @(negedge clk);
    rst = 0;
    repeat (5) @(negedge clk);
    rdchk();
    // All ones first, so reserved bits are tried; then random words and contexts
    for (int i = 0; i < 24; i++)
    begin
      {an, ssl, dup, afd, a100, eta} = 6'($urandom);
      d = (i == 0) ? 32'hFFFFFFFF : $urandom;
      wr(i[0], d);
      {lb, ct, hb, en} = {d[14], d[7], d[0], 1'h1};
      @(posedge clk) {v, b} = {htv, htd};
      @(negedge clk);
      chk({hsv, erv, (lb ? erd : hsd) & {8{v}}}, {v & !lb, v & lb, b & {8{v}}});
      chk({col, hbd}, {ct & eta, hb});
      rdchk();
    end
    // Soft reset beats a write in the same cycle and reloads the strap level
    strap = 0;
    repeat (4) @(negedge clk);
    {prb, prq} = 2'h3;
    wr(0, 32'h4081);
    {prb, prq, lb, ct, hb} = 5'h0;
    repeat (4) @(negedge clk);
    rdchk();
    end_sim();
  end
endmodule : tb_virtual_phy_special_ctrl_status
`default_nettype wire
